// ===== logic/ffk_key_decoder.sv
`timescale 1ns/1ns
// Operation
// R01 - Quick up press and release adds one step.
// R02 - Holding up repeats increments, faster as the hold goes on.
// R03 - Quick down press and release subtracts one step.
// R04 - Holding down repeats decrements, faster as the hold goes on.
// R05 - Short scroll press alone selects the next menu entry.
// R06 - Scroll held 3 s or more issues enter.
// R07 - Scroll held 6 s or more resets peak records.
// R08 - Scroll with up selects the previous menu entry.
// R09 - Scroll with down steps operating mode cyclically.
// R10 - Up with down resets display, ends tuning or manual, leaves sleep.
// R11 - Up with down held 3 s enters sleep when sleep is enabled.
// R12 - All three keys offer factory functions, run only after correct code.
// R13 - Lockout blocks parameter adjustment and calibration entry.
// R14 - Lockout still allows menu navigation and viewing.
// R15 - Up to five pick slots head the user menu.
// R16 - Default switch gives thermocouple/RTD input one and no locks.
// R17 - Keys debounced; combos need all keys; combos suppress single actions.
// R18 - Hold timing covers one press; peak reset replaces enter.
module ffk_key_decoder
  import ffk_pkg::*;
#(
  // Derived counts follow their base, so scaling the base keeps the time ratios
  parameter int unsigned DEB_CYC    = ms_to_cyc(DEB_MS),
  parameter int unsigned ENTER_CYC  = ms_to_cyc(HOLD_ENTER_MS),
  parameter int unsigned PEAK_CYC   = ENTER_CYC * (HOLD_PEAK_MS / HOLD_ENTER_MS),
  parameter int unsigned SLEEP_CYC  = ENTER_CYC * (HOLD_SLEEP_MS / HOLD_ENTER_MS),
  parameter int unsigned RDELAY_CYC = ms_to_cyc(REP_DELAY_MS),
  parameter int unsigned RSLOW_CYC  = ms_to_cyc(REP_SLOW_MS),
  parameter int unsigned RFAST_CYC  = RSLOW_CYC / (REP_SLOW_MS / REP_FAST_MS),
  parameter int unsigned ACCEL_CYC  = RDELAY_CYC * (ACCEL_MS / REP_DELAY_MS)
)(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Front panel keys, high while pressed
  input  wire logic               key_up,
  input  wire logic               key_down,
  input  wire logic               key_scroll,
  // Configuration
  input  wire logic               lockout,
  input  wire logic               sleep_function_enable,
  input  wire logic               sw_in1_linear,
  input  wire logic               security_code_ok,
  // Pick slot access
  input  wire logic               slot_wr,
  input  wire logic [SLOT_AW-1:0] slot_wr_idx,
  input  wire logic [SLOT_DW-1:0] slot_wr_data,
  input  wire logic [SLOT_AW-1:0] slot_rd_idx,
  output logic      [SLOT_DW-1:0] user_menu_pick_slots_q,
  // Command pulses
  output logic                    cmd_inc_q,
  output logic                    cmd_dec_q,
  output logic                    cmd_next_q,
  output logic                    cmd_prev_q,
  output logic                    cmd_enter_q,
  output logic                    cmd_peak_reset_q,
  output logic                    cmd_mode_q,
  output logic                    cmd_reset_q,
  output logic                    cmd_sleep_q,
  output logic                    cmd_factory_q,
  output logic                    factory_exec_q,
  output logic                    adj_blocked_q,
  // Status levels
  output logic                    sleep_active_q,
  output logic                    factory_armed_q,
  output logic                    cal_allowed_q,
  output logic                    in1_tc_rtd_q,
  output logic      [MODE_W-1:0]  op_mode_q
);
  typedef struct packed {
    ffk_state_e       st;
    logic [2:0]       kraw;
    logic [2:0]       kstab;
    logic [2:0][31:0] deb;
    logic [2:0]       keyset;
    logic [31:0]      hold;
    logic [31:0]      rep;
    logic             rep_fired;
    logic             combo_done;
    logic             inc;
    logic             dec;
    logic             nxt;
    logic             prv;
    logic             ent;
    logic             peak;
    logic             mode_cmd;
    logic             rst_cmd;
    logic             slp_cmd;
    logic             fac_cmd;
    logic             fac_exec;
    logic             blocked;
    logic             sleep;
    logic             armed;
    logic             cal_ok;
    logic             in1;
    logic [MODE_W-1:0] mode;
  } ffk_core_s;

  ffk_core_s r_q, r_d;

  function automatic logic [MODE_W-1:0] mode_after(input logic [MODE_W-1:0] m);
    return (m >= MODE_LAST) ? MODE_FIRST : m + MODE_STEP;
  endfunction

  function automatic logic [1:0] key_count(input logic [2:0] k);
    return {1'b0, k[0]} + {1'b0, k[1]} + {1'b0, k[2]};
  endfunction

  logic        do_adj;
  logic        adj_up;
  logic [31:0] rep_thr;

  always_comb begin
    r_d        = r_q;
    do_adj     = 1'b0;
    adj_up     = 1'b0;
    rep_thr    = RDELAY_CYC;
    r_d.inc      = 1'b0;
    r_d.dec      = 1'b0;
    r_d.nxt      = 1'b0;
    r_d.prv      = 1'b0;
    r_d.ent      = 1'b0;
    r_d.peak     = 1'b0;
    r_d.mode_cmd = 1'b0;
    r_d.rst_cmd  = 1'b0;
    r_d.slp_cmd  = 1'b0;
    r_d.fac_cmd  = 1'b0;
    r_d.fac_exec = 1'b0;
    r_d.blocked  = 1'b0;
    r_d.cal_ok   = ~lockout; // [R13]
    r_d.in1      = ~sw_in1_linear; // [R16]
    r_d.kraw     = {key_scroll, key_down, key_up};

    // Debounce: a key flips only after its raw level stays different long enough
    for (int i = 0; i < 3; i++) begin
      if (r_q.kraw[i] != r_q.kstab[i]) begin
        if (r_q.deb[i] >= DEB_CYC - 1) begin // [R17]
          r_d.kstab[i] = r_q.kraw[i];
          r_d.deb[i]   = '0;
        end else begin
          r_d.deb[i] = r_q.deb[i] + 32'h1;
        end
      end else begin
        r_d.deb[i] = '0;
      end
    end

    // One continuous press, saturating so long holds never wrap
    if (r_q.st != FFK_IDLE && r_q.hold < PEAK_CYC) begin
      r_d.hold = r_q.hold + 32'h1; // [R18]
    end

    unique case (r_q.st)
      FFK_IDLE: begin
        r_d.hold       = '0;
        r_d.rep        = '0;
        r_d.rep_fired  = 1'b0;
        r_d.combo_done = 1'b0;
        r_d.keyset     = r_q.kstab;
        if (r_q.kstab != KEYS_NONE) begin
          r_d.st = (key_count(r_q.kstab) >= 2'h2) ? FFK_COMBO : FFK_PRESS;
        end
      end
      FFK_PRESS: begin
        if (key_count(r_q.kstab) >= 2'h2) begin
          // Second key joined: drop any single action still pending
          r_d.st     = FFK_COMBO; // [R17]
          r_d.keyset = r_q.keyset | r_q.kstab;
        end else if (r_q.kstab == KEYS_NONE) begin
          r_d.st = FFK_IDLE;
          if (r_q.keyset == KEY_SC) begin
            if (r_q.hold >= PEAK_CYC) begin
              r_d.peak = 1'b1; // [R07] [R18]
            end else if (r_q.hold >= ENTER_CYC) begin
              r_d.ent = 1'b1; // [R06]
            end else begin
              r_d.nxt = 1'b1; // [R05] [R14]
            end
          end else if (!r_q.rep_fired) begin
            // Quick tap acts on release so a combo can still claim the key
            do_adj = 1'b1; // [R01] [R03]
            adj_up = (r_q.keyset == KEY_UP);
          end
        end else if (r_q.kstab != r_q.keyset) begin
          // One key swapped for another without a gap: start over
          r_d.st = FFK_IDLE;
        end else if (r_q.keyset != KEY_SC) begin
          // Auto-repeat; the period shortens once the hold is long
          if (!r_q.rep_fired) begin
            rep_thr = RDELAY_CYC;
          end else if (r_q.hold >= ACCEL_CYC) begin
            rep_thr = RFAST_CYC; // [R02] [R04]
          end else begin
            rep_thr = RSLOW_CYC;
          end
          if (r_q.rep >= rep_thr - 32'h1) begin
            r_d.rep       = '0;
            r_d.rep_fired = 1'b1;
            do_adj        = 1'b1; // [R02] [R04]
            adj_up        = (r_q.keyset == KEY_UP);
          end else begin
            r_d.rep = r_q.rep + 32'h1;
          end
        end
      end
      FFK_COMBO: begin
        r_d.keyset = r_q.keyset | r_q.kstab; // [R17]
        if (r_q.keyset == KEYS_UD && r_q.kstab == KEYS_UD && !r_q.combo_done &&
            r_q.hold >= SLEEP_CYC) begin
          // Sleep hold replaces the reset that release would give
          r_d.combo_done = 1'b1;
          if (sleep_function_enable) begin
            r_d.slp_cmd = 1'b1; // [R11]
            r_d.sleep   = 1'b1;
          end
        end
        if (r_q.kstab == KEYS_NONE) begin
          r_d.st = FFK_IDLE;
          if (!r_q.combo_done) begin
            unique case (r_q.keyset)
              KEYS_ALL: begin
                r_d.fac_cmd = 1'b1; // [R12]
                r_d.armed   = 1'b1;
              end
              KEYS_UD: begin
                r_d.rst_cmd = 1'b1; // [R10]
                r_d.sleep   = 1'b0;
                r_d.armed   = 1'b0;
              end
              KEYS_SU: r_d.prv = 1'b1; // [R08] [R14]
              KEYS_SD: begin
                r_d.mode_cmd = 1'b1; // [R09]
                r_d.mode     = mode_after(r_q.mode);
              end
              default: ;
            endcase
          end
        end
      end
      default: r_d.st = FFK_IDLE;
    endcase

    if (do_adj) begin
      if (lockout) begin
        r_d.blocked = 1'b1; // [R13]
      end else begin
        r_d.inc = adj_up;
        r_d.dec = ~adj_up;
      end
    end

    // Factory programs run only on a correct code while armed
    if (r_q.armed && security_code_ok) begin
      r_d.fac_exec = 1'b1; // [R12]
      // A fresh arming in the same cycle wins over the clear
      r_d.armed    = r_d.fac_cmd;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q        <= '0;
      r_q.st     <= FFK_IDLE;
      r_q.in1    <= IN1_TC_RTD; // [R16]
      r_q.cal_ok <= 1'b1; // [R16]
      r_q.mode   <= MODE_FIRST;
    end else begin
      r_q <= r_d;
    end
  end

  assign cmd_inc_q        = r_q.inc;
  assign cmd_dec_q        = r_q.dec;
  assign cmd_next_q       = r_q.nxt;
  assign cmd_prev_q       = r_q.prv;
  assign cmd_enter_q      = r_q.ent;
  assign cmd_peak_reset_q = r_q.peak;
  assign cmd_mode_q       = r_q.mode_cmd;
  assign cmd_reset_q      = r_q.rst_cmd;
  assign cmd_sleep_q      = r_q.slp_cmd;
  assign cmd_factory_q    = r_q.fac_cmd;
  assign factory_exec_q   = r_q.fac_exec;
  assign adj_blocked_q    = r_q.blocked;
  assign sleep_active_q   = r_q.sleep;
  assign factory_armed_q  = r_q.armed;
  assign cal_allowed_q    = r_q.cal_ok;
  assign in1_tc_rtd_q     = r_q.in1;
  assign op_mode_q        = r_q.mode;

  ffk_slot_mem u_slots (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wr_en     (slot_wr),
    .wr_idx    (slot_wr_idx),
    .wr_data   (slot_wr_data),
    .rd_idx    (slot_rd_idx),
    .rd_data_q (user_menu_pick_slots_q)
  );

  sequence s_scroll_release;
    r_q.st == FFK_PRESS && r_q.keyset == KEY_SC && r_q.kstab == KEYS_NONE;
  endsequence

  chk_adj_lock: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    (cmd_inc_q || cmd_dec_q) |-> $past(!lockout))
    else $error("adjust issued under lockout");
  chk_blocked_cause: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    adj_blocked_q |-> $past(lockout) && !cmd_inc_q && !cmd_dec_q)
    else $error("blocked pulse without lockout");
  chk_enter_window: assert property (@(posedge clk) disable iff (sys_rst) // [R06]
    s_scroll_release ##0 (r_q.hold >= ENTER_CYC && r_q.hold < PEAK_CYC)
    |=> cmd_enter_q && !cmd_peak_reset_q)
    else $error("enter not issued for mid hold");
  chk_peak_only: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
    s_scroll_release ##0 (r_q.hold >= PEAK_CYC) |=> cmd_peak_reset_q && !cmd_enter_q)
    else $error("long hold gave wrong command");
  chk_short_next: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
    s_scroll_release ##0 (r_q.hold < ENTER_CYC) |=> cmd_next_q)
    else $error("short scroll did not advance");
  chk_one_command: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
    $onehot0({cmd_inc_q, cmd_dec_q, cmd_next_q, cmd_prev_q, cmd_enter_q,
              cmd_peak_reset_q, cmd_mode_q, cmd_reset_q, cmd_sleep_q, cmd_factory_q}))
    else $error("more than one command at once");
  chk_sleep_gate: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    cmd_sleep_q |-> $past(sleep_function_enable) && sleep_active_q)
    else $error("sleep without enable");
  chk_reset_wake: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    cmd_reset_q |-> !sleep_active_q && !factory_armed_q)
    else $error("reset left sleep or factory armed");
  chk_mode_cycle: assert property (@(posedge clk) disable iff (sys_rst) // [R09]
    cmd_mode_q |-> op_mode_q == mode_after($past(op_mode_q)))
    else $error("mode did not step in order");
  chk_factory_code: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    factory_exec_q |-> $past(factory_armed_q && security_code_ok))
    else $error("factory run without code");
  chk_default_in1: assert property (@(posedge clk) // [R16]
    sys_rst |=> in1_tc_rtd_q && cal_allowed_q)
    else $error("reset default wrong");
endmodule // ffk_key_decoder

// ===== common/ffk_pkg.sv
package ffk_pkg;
  // Timing base
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  // Times in milliseconds
  localparam int unsigned DEB_MS        = 20;
  localparam int unsigned HOLD_ENTER_MS = 3000;
  localparam int unsigned HOLD_PEAK_MS  = 6000;
  localparam int unsigned HOLD_SLEEP_MS = 3000;
  localparam int unsigned REP_DELAY_MS  = 500;
  localparam int unsigned REP_SLOW_MS   = 250;
  localparam int unsigned REP_FAST_MS   = 50;
  localparam int unsigned ACCEL_MS      = 2000;

  function automatic int unsigned ms_to_cyc(input int unsigned ms);
    return CYC_PER_MS * ms;
  endfunction

  // Key masks, bit 0 up, bit 1 down, bit 2 scroll
  localparam logic [2:0] KEYS_NONE = 3'h0;
  localparam logic [2:0] KEY_UP    = 3'h1;
  localparam logic [2:0] KEY_DN    = 3'h2;
  localparam logic [2:0] KEY_SC    = 3'h4;
  localparam logic [2:0] KEYS_UD   = 3'h3;
  localparam logic [2:0] KEYS_SU   = 3'h5;
  localparam logic [2:0] KEYS_SD   = 3'h6;
  localparam logic [2:0] KEYS_ALL  = 3'h7;

  // User menu pick slots
  localparam int unsigned SLOT_NUM  = 5;
  localparam int unsigned SLOT_AW   = 3;
  localparam int unsigned SLOT_DW   = 8;
  localparam logic [SLOT_DW-1:0] SLOT_RST = 8'h00;

  // Operating modes, cycled in order 0 .. MODE_LAST
  localparam int unsigned MODE_W    = 3;
  localparam logic [MODE_W-1:0] MODE_FIRST = 3'h0;
  localparam logic [MODE_W-1:0] MODE_LAST  = 3'h4;
  localparam logic [MODE_W-1:0] MODE_STEP  = 3'h1;

  // Input 1 sensor class: 1 = thermocouple/RTD, 0 = linear
  localparam logic IN1_TC_RTD = 1'b1;

  typedef enum logic [1:0] {
    FFK_IDLE  = 2'b00,
    FFK_PRESS = 2'b01,
    FFK_COMBO = 2'b11
  } ffk_state_e;
endpackage

// ===== logic/ffk_slot_mem.sv
`timescale 1ns/1ns
module ffk_slot_mem
  import ffk_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Write side
  input  wire logic               wr_en,
  input  wire logic [SLOT_AW-1:0] wr_idx,
  input  wire logic [SLOT_DW-1:0] wr_data,
  // Read side
  input  wire logic [SLOT_AW-1:0] rd_idx,
  output logic      [SLOT_DW-1:0] rd_data_q
);
  logic [SLOT_NUM-1:0][SLOT_DW-1:0] mem_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_q     <= '0;
      rd_data_q <= SLOT_RST;
    end else begin
      // Indices beyond the last slot are ignored
      if (wr_en && (wr_idx < SLOT_AW'(SLOT_NUM))) begin // [R15]
        mem_q[wr_idx] <= wr_data;
      end
      rd_data_q <= (rd_idx < SLOT_AW'(SLOT_NUM)) ? mem_q[rd_idx] : SLOT_RST; // [R15]
    end
  end
endmodule // ffk_slot_mem

// ===== verif/ffk_operator.sv
`timescale 1ns/1ns
module ffk_operator (
  // Clock
  input  wire logic clk,
  // Keys, high while pressed
  output logic      key_up,
  output logic      key_down,
  output logic      key_scroll
);
  initial begin
    key_up     = 1'b0;
    key_down   = 1'b0;
    key_scroll = 1'b0;
  end

  // Keys of one gesture go down and up together, so a combo is never seen partial
  task automatic press(input logic [2:0] mask, input int hold);
    @(negedge clk);
    {key_scroll, key_down, key_up} = mask;
    repeat (hold) @(negedge clk);
    {key_scroll, key_down, key_up} = 3'h0;
  endtask
endmodule // ffk_operator

// ===== verif/front_panel_key_decoder_bench.sv
`timescale 1ns/1ns
module front_panel_key_decoder_bench;
  import ffk_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              key_up, key_down, key_scroll;
  logic              lockout = 1'b0;
  logic              sleep_function_enable = 1'b0;
  logic              sw_in1_linear = 1'b0;
  logic              security_code_ok = 1'b0;
  logic              slot_wr = 1'b0;
  logic [SLOT_AW-1:0] slot_wr_idx = 3'h0;
  logic [SLOT_DW-1:0] slot_wr_data = 8'h00;
  logic [SLOT_AW-1:0] slot_rd_idx = 3'h0;
  logic [SLOT_DW-1:0] rd_data;
  wire  [11:0]       cmds;
  logic              sleep_act, armed, cal_ok, in1_tc;
  logic [MODE_W-1:0] op_mode;
  logic [7:0]        cnt [12] = '{default: 8'h00};
  logic [7:0]        b;
  int                err_count = 0;
  int                total_checks = 0;

  always #10 clk = ~clk;

  ffk_operator i_ffk_operator (.clk(clk), .key_up(key_up), .key_down(key_down),
    .key_scroll(key_scroll));

  // Short counts keep the run brief; all expectations derive from these values
  // Peak 80, sleep 40, fast repeat 1 and acceleration 40 follow from these
  ffk_key_decoder #(.DEB_CYC(4), .ENTER_CYC(40), .RDELAY_CYC(10), .RSLOW_CYC(6))
    i_ffk_key_decoder (
    .clk(clk), .sys_rst(sys_rst), .key_up(key_up), .key_down(key_down),
    .key_scroll(key_scroll), .lockout(lockout),
    .sleep_function_enable(sleep_function_enable), .sw_in1_linear(sw_in1_linear),
    .security_code_ok(security_code_ok), .slot_wr(slot_wr), .slot_wr_idx(slot_wr_idx),
    .slot_wr_data(slot_wr_data), .slot_rd_idx(slot_rd_idx),
    .user_menu_pick_slots_q(rd_data), .cmd_inc_q(cmds[0]), .cmd_dec_q(cmds[1]),
    .cmd_next_q(cmds[2]), .cmd_prev_q(cmds[3]), .cmd_enter_q(cmds[4]),
    .cmd_peak_reset_q(cmds[5]), .cmd_mode_q(cmds[6]), .cmd_reset_q(cmds[7]),
    .cmd_sleep_q(cmds[8]), .cmd_factory_q(cmds[9]), .factory_exec_q(cmds[10]),
    .adj_blocked_q(cmds[11]), .sleep_active_q(sleep_act), .factory_armed_q(armed),
    .cal_allowed_q(cal_ok), .in1_tc_rtd_q(in1_tc), .op_mode_q(op_mode));

  // Pulses stand one cycle, so they are counted at every edge
  always @(posedge clk) begin
    for (int i = 0; i < 12; i++) begin
      if (cmds[i] === 1'b1) cnt[i] <= cnt[i] + 8'h01;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Nibble i of exp is the expected count of command i; f leaves it unchecked
  task automatic gesture(input logic [2:0] m, input int h, input logic [47:0] exp);
    logic [7:0] base [12];
    base = cnt;
    i_ffk_operator.press(m, h);
    repeat (20) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      if (exp[i*4 +: 4] != 4'hf) chk(cnt[i] - base[i], {4'h0, exp[i*4 +: 4]});
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({7'h0, in1_tc}, 8'h01);
    chk({7'h0, cal_ok}, 8'h01);
    chk({5'h0, op_mode}, 8'h00);
    sw_in1_linear = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h0, in1_tc}, 8'h00);
    sw_in1_linear = 1'b0;
    // Pick slots: 5..7 are out of range and must read back empty
    for (int i = 0; i < 8; i++) begin
      slot_wr = 1'b1;
      slot_wr_idx = i[2:0];
      slot_wr_data = 8'ha0 + i[7:0];
      @(negedge clk);
    end
    slot_wr = 1'b0;
    for (int i = 0; i < 8; i++) begin
      slot_rd_idx = i[2:0];
      @(negedge clk);
      chk(rd_data, (i < 5) ? 8'ha0 + i[7:0] : 8'h00);
    end
    gesture(KEY_UP, 2, 48'h0);
    gesture(KEY_UP, 6, 48'h1);
    gesture(KEY_DN, 6, 48'h10);
    // Held keys: slow repeats alone give about 9, acceleration lifts it well past 12
    for (int k = 0; k < 2; k++) begin
      b = cnt[k];
      gesture(k[0] ? KEY_DN : KEY_UP, 60, k[0] ? 48'hf0 : 48'hf);
      chk({7'h0, (cnt[k] - b) >= 8'd12}, 8'h01);
    end
    gesture(KEY_SC, 6, 48'h100);
    gesture(KEY_SC, 50, 48'h1_0000);
    gesture(KEY_SC, 90, 48'h10_0000);
    gesture(KEYS_SU, 6, 48'h1000);
    for (int i = 0; i < 6; i++) begin
      gesture(KEYS_SD, 6, 48'h100_0000);
      chk({5'h0, op_mode}, 8'((i + 1) % 5));
    end
    gesture(KEYS_UD, 50, 48'h0);
    chk({7'h0, sleep_act}, 8'h00);
    sleep_function_enable = 1'b1;
    gesture(KEYS_UD, 50, 48'h1_0000_0000);
    chk({7'h0, sleep_act}, 8'h01);
    gesture(KEYS_UD, 6, 48'h1000_0000);
    chk({7'h0, sleep_act}, 8'h00);
    gesture(KEYS_ALL, 6, 48'h10_0000_0000);
    chk({7'h0, armed}, 8'h01);
    b = cnt[10];
    security_code_ok = 1'b1;
    repeat (3) @(negedge clk);
    chk(cnt[10] - b, 8'h01);
    chk({7'h0, armed}, 8'h00);
    security_code_ok = 1'b0;
    lockout = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h0, cal_ok}, 8'h00);
    gesture(KEY_UP, 6, 48'h1000_0000_0000);
    gesture(KEY_DN, 6, 48'h1000_0000_0000);
    gesture(KEY_SC, 6, 48'h100);
    gesture(KEYS_SU, 6, 48'h1000);
    lockout = 1'b0;
    tally_and_finish();
  end
endmodule // front_panel_key_decoder_bench
